// File: logic/epdhcd_coord.v
/*
  partial-area corner store: takes the eight coordinate bytes and works out
  how many pixel data bytes the area needs at the present depth.
  assumes corners give an inclusive rectangle with x2 >= x1 and y2 >= y1.
*/
`include "epdhcd_defines.vh"

module epdhcd_coord (
  input wire ref_clk,
  input wire rst,
  input wire wr,
  input wire [2:0] idx,
  input wire [7:0] wdata,
  input wire depth2,
  output reg [15:0] x1_r,
  output reg [15:0] y1_r,
  output reg [15:0] x2_r,
  output reg [15:0] y2_r,
  output wire [16:0] byte_total
);

  // area bytes: one bit per pixel packs 8 pixels a byte, two bits pack 4
  function [16:0] area_bytes;
    input [15:0] a1;
    input [15:0] b1;
    input [15:0] a2;
    input [15:0] b2;
    input two;
    reg [31:0] px;
    begin
      px = ({16'h0000, a2} - {16'h0000, a1} + 32'h0000_0001) *
           ({16'h0000, b2} - {16'h0000, b1} + 32'h0000_0001);
      area_bytes = two ? px[18:2] : px[19:3];
    end
  endfunction

  assign byte_total = area_bytes(x1_r, y1_r, x2_r, y2_r, depth2);

  // ==========================================
  // high byte of each value first; x then y, top-left corner before bottom-right
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      x1_r <= 16'h0000;
      y1_r <= 16'h0000;
      x2_r <= 16'h0000;
      y2_r <= 16'h0000;
    end
    else if (wr)
    begin
      case (idx)
        3'h0: x1_r[15:8] <= wdata; // see R09
        3'h1: x1_r[7:0] <= wdata;
        3'h2: y1_r[15:8] <= wdata;
        3'h3: y1_r[7:0] <= wdata;
        3'h4: x2_r[15:8] <= wdata;
        3'h5: x2_r[7:0] <= wdata;
        3'h6: y2_r[15:8] <= wdata;
        3'h7: y2_r[7:0] <= wdata;
        default: x1_r <= x1_r;
      endcase
    end
  end

endmodule

// File: logic/epdhcd_defines.vh
/*
  constants of the host command decoder: command codes, argument values,
  status byte layout, picture states, power modes and reset values.
  assumes inclusion by bare name from every design file of the block.
*/
// Function
// R01: init with argument 0x00 rewrites only the image memories to all white.
// R02: init with argument 0x01 drives panel and memories to all white.
// R03: after an init with argument zero completes, refresh the shown picture.
// R04: restore picture 0xA5, normal mode only, redisplays previous image, memories kept.
// R05: get status 0xAA returns one status byte, normal or sleep mode.
// R06: status bit0 sleep, bit3 auto refresh, bit4 two-bit depth, bits7-5 reserved.
// R07: status bits 2:1 give none, loaded, displayed or load aborted.
// R08: host issues a display after each partial load before the next one.
// R09: partial load takes eight coordinate bytes, top-left first, then pixel data.
// R10: host keeps partial coordinates on a four-pixel grid.
// R11: partial load ends on full data count or on stop loading.
// R12: display partial 0xB1 behaves exactly as display picture.
// R13: display picture 0xA2, normal mode only, updates the panel.
// R14: version 0xE0 returns one version byte, normal or sleep mode.
// R15: display size 0xE2 returns 0x22 in normal or sleep mode.
// R16: soft reset 0xEE resets the device completely, normal or sleep.
// R17: soft reset acts when the strobe returns high; others act at acknowledge.
// R18: host waits 20 microseconds after soft reset before the next command.
// R19: sleep 0xF1 stops the fast clock; normal 0xF0 only valid in sleep.
// R20: standby 0xF2 halts everything, host port included, until wake-up.
// R21: host sends nothing after standby and waits 600 microseconds before wake-up.
// R22: set depth 0xF3 argument 0x00 one bit, 0x02 two bits, others reserved.
// R23: orientation 0xF5 argument 0 to 3, affects later loads, default 90 degrees.
// R24: positive picture 0xF7 selects un-reversed gradation, also the reset state.
// R25: commands not valid in the present power mode are ignored.
`ifndef EPDHCD_DEFINES_VH
`define EPDHCD_DEFINES_VH

// ==========================================
// command codes
`define EPDHCD_CMD_STOP 8'hA1
`define EPDHCD_CMD_DISP 8'hA2
`define EPDHCD_CMD_INIT 8'hA4
`define EPDHCD_CMD_RESTORE 8'hA5
`define EPDHCD_CMD_STATUS 8'hAA
`define EPDHCD_CMD_PLOAD 8'hB0
`define EPDHCD_CMD_PDISP 8'hB1
`define EPDHCD_CMD_VERSION 8'hE0
`define EPDHCD_CMD_SIZE 8'hE2
`define EPDHCD_CMD_RESET 8'hEE
`define EPDHCD_CMD_NORMAL 8'hF0
`define EPDHCD_CMD_SLEEP 8'hF1
`define EPDHCD_CMD_STANDBY 8'hF2
`define EPDHCD_CMD_DEPTH 8'hF3
`define EPDHCD_CMD_ORIENT 8'hF5
`define EPDHCD_CMD_POS 8'hF7
`define EPDHCD_CMD_NEG 8'hF8

// ==========================================
// argument values and fixed answers
`define EPDHCD_INIT_KNOWN 8'h00
`define EPDHCD_INIT_UNKNOWN 8'h01
`define EPDHCD_DEPTH_1BIT 8'h00
`define EPDHCD_DEPTH_2BIT 8'h02
`define EPDHCD_ORIENT_MAX 8'h03
`define EPDHCD_SIZE_CODE 8'h22
`define EPDHCD_COORD_BYTES 3'h7

// ==========================================
// status byte fields and picture states
`define EPDHCD_ST_MODE 0
`define EPDHCD_ST_PIC_LO 1
`define EPDHCD_ST_PIC_HI 2
`define EPDHCD_ST_AREF 3
`define EPDHCD_ST_DEPTH 4
`define EPDHCD_PIC_NONE 2'h0
`define EPDHCD_PIC_LOADED 2'h1
`define EPDHCD_PIC_SHOWN 2'h2
`define EPDHCD_PIC_ABORT 2'h3

// ==========================================
// power modes and reset values
`define EPDHCD_MODE_NORMAL 2'h0
`define EPDHCD_MODE_SLEEP 2'h1
`define EPDHCD_MODE_STANDBY 2'h2
`define EPDHCD_ORIENT_RST 2'h1

`endif

// File: logic/epdhcd_fifo.v
/*
  pixel byte fifo between the host port and the image memory writer.
  assumes one clock and a synchronous active-high reset.
*/
`include "epdhcd_defines.vh"

module epdhcd_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire ref_clk,
  input wire rst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;

  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // ==========================================
  // storage has no reset: only words below the count are ever read
  always @(posedge ref_clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
      if (push & ~pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push)
        cnt_r <= cnt_r - 1'b1;
    end
  end

endmodule

// File: logic/epdhcd_top.v
/*
  host command decoder of the display controller: byte-wide host port,
  command and argument decode, return bytes, power modes, partial load
  with a pixel fifo towards the image memory writer.
  assumes host port inputs synchronous to ref_clk and that the panel
  sequencer answers the action pulses; one host byte per strobe cycle.
*/
`include "epdhcd_defines.vh"

module epdhcd_top #(
  parameter [7:0] VERSION_CODE = 8'h01, // arbitrary value
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire ref_clk,
  input wire srst,
  input wire host_data_strobe_n,
  input wire host_rw,
  input wire host_cd,
  input wire [7:0] host_data_in,
  output reg [7:0] host_data_out,
  output wire host_data_oe_n,
  output wire host_ack,
  input wire wake_req,
  input wire auto_refresh_on,
  input wire init_done,
  output wire [7:0] pix_data,
  output wire pix_valid,
  input wire pix_ready,
  output wire [15:0] area_x1,
  output wire [15:0] area_y1,
  output wire [15:0] area_x2,
  output wire [15:0] area_y2,
  output wire partial_busy,
  output reg init_mem_white,
  output reg init_panel_white,
  output reg refresh_req,
  output reg restore_req,
  output reg display_req,
  output reg soft_reset_pulse,
  output wire depth_2bit,
  output wire [1:0] orientation,
  output wire gradation_neg,
  output wire fast_clk_run,
  output wire standby_halt
);

  // ==========================================
  // decoder states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ARG = 3'h1;
  localparam [2:0] ST_COORD = 3'h2;
  localparam [2:0] ST_PDATA = 3'h3;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [7:0] arg_cmd_r;
  reg [1:0] mode_r;
  reg [1:0] pic_r;
  reg depth2_r;
  reg [1:0] orient_r;
  reg neg_r;
  reg ack_r;
  reg rst_pend_r;
  reg soft_rst_r;
  reg ref_pend_r;
  reg [2:0] cidx_r;
  reg [16:0] remain_r;
  reg [7:0] ret_r;
  wire rst;
  wire strobe_on;
  wire new_cycle;
  wire wr_take;
  wire rd_take;
  wire is_cmd;
  wire is_data;
  wire [7:0] status_byte;
  wire [16:0] byte_total;
  wire fifo_in_ready;
  wire fifo_push;

  // soft reset drives the same synchronous reset as srst
  assign rst = srst | soft_rst_r; // see R16

  // ==========================================
  // command validity per power mode
  function cmd_ok;
    input [7:0] cmd;
    input [1:0] mode;
    begin
      case (cmd)
        `EPDHCD_CMD_STATUS,
        `EPDHCD_CMD_VERSION,
        `EPDHCD_CMD_SIZE,
        `EPDHCD_CMD_RESET,
        `EPDHCD_CMD_SLEEP,
        `EPDHCD_CMD_STANDBY:
          cmd_ok = (mode == `EPDHCD_MODE_NORMAL) | (mode == `EPDHCD_MODE_SLEEP);
        `EPDHCD_CMD_NORMAL:
          cmd_ok = (mode == `EPDHCD_MODE_SLEEP); // see R19
        default:
          cmd_ok = (mode == `EPDHCD_MODE_NORMAL); // see R25
      endcase
    end
  endfunction

  // ==========================================
  // host port handshake: one acknowledge per strobe cycle
  // standby ignores the port entirely, the host is not answered
  assign strobe_on = ~host_data_strobe_n;
  assign new_cycle = strobe_on & ~ack_r & (mode_r != `EPDHCD_MODE_STANDBY); // see R20
  // pixel bytes wait for fifo room, which stalls the acknowledge
  assign wr_take = new_cycle & ~host_rw & ~(is_data & (state_r == ST_PDATA) & ~fifo_in_ready);
  assign rd_take = new_cycle & host_rw;
  assign is_cmd = host_cd;
  assign is_data = ~host_cd;
  assign host_ack = ack_r;
  assign host_data_oe_n = ~(ack_r & host_rw & strobe_on);
  assign fifo_push = wr_take & is_data & (state_r == ST_PDATA);

  assign status_byte = {3'h0, depth2_r, auto_refresh_on, pic_r,
                        (mode_r == `EPDHCD_MODE_SLEEP)}; // see R06 R07

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ack_r <= 1'b0;
      rst_pend_r <= 1'b0;
      soft_rst_r <= 1'b0;
      host_data_out <= 8'h00;
    end
    else
    begin
      soft_rst_r <= 1'b0;
      if (wr_take | rd_take)
        ack_r <= 1'b1;
      else if (host_data_strobe_n)
        ack_r <= 1'b0;
      if (rd_take)
        host_data_out <= ret_r;
      // reset waits for the strobe to rise so the acknowledge is seen whole
      if (wr_take & is_cmd & (host_data_in == `EPDHCD_CMD_RESET) & cmd_ok(host_data_in, mode_r))
        rst_pend_r <= 1'b1;
      else if (rst_pend_r & host_data_strobe_n)
      begin
        rst_pend_r <= 1'b0;
        soft_rst_r <= 1'b1; // see R17
      end
    end
  end

  // ==========================================
  // decoder: commands take effect at the acknowledge
  always @*
  begin
    state_nxt = state_r;
    if (wr_take)
    begin
      case (state_r)
        ST_IDLE:
          if (is_cmd & cmd_ok(host_data_in, mode_r))
          begin
            if ((host_data_in == `EPDHCD_CMD_INIT) | (host_data_in == `EPDHCD_CMD_DEPTH) |
                (host_data_in == `EPDHCD_CMD_ORIENT))
              state_nxt = ST_ARG;
            else if (host_data_in == `EPDHCD_CMD_PLOAD)
              state_nxt = ST_COORD; // see R09
          end
        ST_ARG:
          state_nxt = ST_IDLE;
        ST_COORD:
          if (is_cmd & (host_data_in == `EPDHCD_CMD_STOP))
            state_nxt = ST_IDLE;
          else if (is_data & (cidx_r == `EPDHCD_COORD_BYTES))
            state_nxt = ST_PDATA;
        ST_PDATA:
          if (is_cmd & (host_data_in == `EPDHCD_CMD_STOP))
            state_nxt = ST_IDLE; // see R11
          else if (is_data & (remain_r == 17'h0_0001))
            state_nxt = ST_IDLE; // see R11
        default:
          state_nxt = ST_IDLE;
      endcase
    end
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      arg_cmd_r <= 8'h00;
      mode_r <= `EPDHCD_MODE_NORMAL;
      pic_r <= `EPDHCD_PIC_NONE;
      depth2_r <= 1'b0;
      orient_r <= `EPDHCD_ORIENT_RST; // see R23
      neg_r <= 1'b0; // see R24
      cidx_r <= 3'h0;
      remain_r <= 17'h0_0000;
      ret_r <= 8'h00;
      ref_pend_r <= 1'b0;
      init_mem_white <= 1'b0;
      init_panel_white <= 1'b0;
      refresh_req <= 1'b0;
      restore_req <= 1'b0;
      display_req <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      init_mem_white <= 1'b0;
      init_panel_white <= 1'b0;
      refresh_req <= 1'b0;
      restore_req <= 1'b0;
      display_req <= 1'b0;
      soft_reset_pulse <= rst_pend_r & host_data_strobe_n;
      if (mode_r == `EPDHCD_MODE_STANDBY)
      begin
        if (wake_req)
          mode_r <= `EPDHCD_MODE_NORMAL;
      end
      // refresh follows the memory-only init once the sequencer finishes it
      if (ref_pend_r & init_done)
      begin
        ref_pend_r <= 1'b0;
        refresh_req <= 1'b1; // see R03
      end
      if (wr_take)
      begin
        case (state_r)
          ST_IDLE:
            if (is_cmd & cmd_ok(host_data_in, mode_r))
            begin
              arg_cmd_r <= host_data_in;
              cidx_r <= 3'h0;
              case (host_data_in)
                `EPDHCD_CMD_DISP,
                `EPDHCD_CMD_PDISP:
                begin
                  display_req <= 1'b1; // see R12 R13
                  pic_r <= `EPDHCD_PIC_SHOWN;
                end
                `EPDHCD_CMD_RESTORE:
                begin
                  restore_req <= 1'b1; // see R04
                  pic_r <= `EPDHCD_PIC_SHOWN;
                end
                `EPDHCD_CMD_STATUS: ret_r <= status_byte; // see R05
                `EPDHCD_CMD_VERSION: ret_r <= VERSION_CODE; // see R14
                `EPDHCD_CMD_SIZE: ret_r <= `EPDHCD_SIZE_CODE; // see R15
                `EPDHCD_CMD_NORMAL: mode_r <= `EPDHCD_MODE_NORMAL;
                `EPDHCD_CMD_SLEEP: mode_r <= `EPDHCD_MODE_SLEEP; // see R19
                `EPDHCD_CMD_STANDBY: mode_r <= `EPDHCD_MODE_STANDBY; // see R20
                `EPDHCD_CMD_POS: neg_r <= 1'b0; // see R24
                `EPDHCD_CMD_NEG: neg_r <= 1'b1;
                default: ret_r <= ret_r;
              endcase
            end
          ST_ARG:
            if (is_data)
            begin
              case (arg_cmd_r)
                `EPDHCD_CMD_INIT:
                  if (host_data_in == `EPDHCD_INIT_KNOWN)
                  begin
                    init_mem_white <= 1'b1; // see R01
                    ref_pend_r <= 1'b1; // see R03
                    pic_r <= `EPDHCD_PIC_SHOWN;
                  end
                  else if (host_data_in == `EPDHCD_INIT_UNKNOWN)
                  begin
                    init_panel_white <= 1'b1; // see R02
                    pic_r <= `EPDHCD_PIC_SHOWN;
                  end
                `EPDHCD_CMD_DEPTH:
                  // reserved depth codes leave the setting alone
                  if (host_data_in == `EPDHCD_DEPTH_1BIT)
                    depth2_r <= 1'b0; // see R22
                  else if (host_data_in == `EPDHCD_DEPTH_2BIT)
                    depth2_r <= 1'b1; // see R22
                `EPDHCD_CMD_ORIENT:
                  if (host_data_in <= `EPDHCD_ORIENT_MAX)
                    orient_r <= host_data_in[1:0]; // see R23
                default:
                  arg_cmd_r <= arg_cmd_r;
              endcase
            end
          ST_COORD:
            if (is_data)
            begin
              cidx_r <= cidx_r + 3'h1;
              if (cidx_r == `EPDHCD_COORD_BYTES)
                remain_r <= byte_total_next(byte_total, host_data_in, depth2_r);
            end
            else if (host_data_in == `EPDHCD_CMD_STOP)
              pic_r <= `EPDHCD_PIC_ABORT;
          ST_PDATA:
            if (is_data)
            begin
              remain_r <= remain_r - 17'h0_0001;
              if (remain_r == 17'h0_0001)
                pic_r <= `EPDHCD_PIC_LOADED; // see R07
            end
            else if (host_data_in == `EPDHCD_CMD_STOP)
              pic_r <= `EPDHCD_PIC_ABORT; // see R07 R11
          default:
            state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // the last coordinate byte lands in the store this same edge, so the count
  // is taken from the store's output with that byte patched in
  function [16:0] byte_total_next;
    input [16:0] cur;
    input [7:0] last;
    input two;
    reg [31:0] px;
    begin
      px = ({16'h0000, area_x2} - {16'h0000, area_x1} + 32'h0000_0001) *
           ({16'h0000, area_y2[15:8], last} - {16'h0000, area_y1} + 32'h0000_0001);
      byte_total_next = (cur == 17'h0_0000) ? 17'h0_0000 : (two ? px[18:2] : px[19:3]);
      if (byte_total_next == 17'h0_0000)
        byte_total_next = two ? px[18:2] : px[19:3];
    end
  endfunction

  // ==========================================
  // coordinate store and pixel fifo
  epdhcd_coord u_coord (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr(wr_take & is_data & (state_r == ST_COORD)),
    .idx(cidx_r),
    .wdata(host_data_in),
    .depth2(depth2_r),
    .x1_r(area_x1),
    .y1_r(area_y1),
    .x2_r(area_x2),
    .y2_r(area_y2),
    .byte_total(byte_total)
  );

  epdhcd_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_data(host_data_in),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .out_data(pix_data),
    .out_valid(pix_valid),
    .out_ready(pix_ready)
  );

  assign partial_busy = (state_r == ST_COORD) | (state_r == ST_PDATA);
  assign depth_2bit = depth2_r;
  assign orientation = orient_r;
  assign gradation_neg = neg_r;
  assign fast_clk_run = (mode_r == `EPDHCD_MODE_NORMAL); // see R19
  assign standby_halt = (mode_r == `EPDHCD_MODE_STANDBY); // see R20

endmodule

// File: verif/epdhcd_host_model.sv
/*
  host processor model for the byte-wide host port of the command decoder.
  assumes the device acknowledges with an active-high level and a clock on ref_clk.
*/
module epdhcd_host_model (
  input wire ref_clk,
  input wire host_ack,
  input wire [7:0] rdata,
  output logic strobe_n,
  output logic rw,
  output logic cd,
  output logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  int lost = 0;
  // ==========================================
  // one strobe cycle per byte
  initial
  begin
    strobe_n = 1'b1;
    rw = 1'b0;
    cd = 1'b0;
    wdata = 8'h00;
  end
  task automatic xfer(input logic r, input logic c, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge ref_clk);
    strobe_n <= 1'b0;
    rw <= r;
    cd <= c;
    wdata <= d;
    n = 0;
    do @(posedge ref_clk); while (host_ack !== 1'b1 && ++n < 200);
    // a refused byte is dropped after the limit, never left hanging
    if (n >= 200)
      lost++;
    q = rdata;
    strobe_n <= 1'b1;
    wdata <= ~d;
    n = 0;
    do @(posedge ref_clk); while (host_ack !== 1'b0 && ++n < 20);
  endtask
endmodule

// File: verif/epdhcd_sva.sv
/*
  checker of the host command decoder, bound to its top module.
  assumes single clock ref_clk and synchronous reset srst.
*/
`include "epdhcd_defines.vh"
module epdhcd_sva (
  input wire ref_clk,
  input wire srst,
  input wire host_data_strobe_n,
  input wire host_rw,
  input wire host_ack,
  input wire host_data_oe_n,
  input wire init_done,
  input wire refresh_req,
  input wire restore_req,
  input wire display_req,
  input wire init_panel_white,
  input wire soft_reset_pulse,
  input wire depth_2bit,
  input wire [1:0] orientation,
  input wire gradation_neg,
  input wire fast_clk_run,
  input wire standby_halt
);
  // ==========================================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_rst_vals;
    orientation == `EPDHCD_ORIENT_RST && !depth_2bit && !gradation_neg && fast_clk_run;
  endsequence
  property p_soft_clear;
    soft_reset_pulse |-> ##[0:2] s_rst_vals;
  endproperty
  a_ack_rise: assert property ($rose(host_ack) |-> $past(!host_data_strobe_n)) else $error("ack without strobe");
  a_ack_drop: assert property (host_data_strobe_n && host_ack |=> !host_ack) else $error("ack held");
  a_oe_drive: assert property (host_rw && $rose(host_ack) |-> !host_data_oe_n) else $error("bad drive");
  a_soft_late: assert property (soft_reset_pulse |-> $past(host_data_strobe_n)) else $error("early reset");
  a_soft_clear: assert property (p_soft_clear) else $error("soft reset kept state");
  a_mode_excl: assert property (!(fast_clk_run && standby_halt)) else $error("two modes");
  a_standby_mute: assert property (standby_halt |=> !$rose(host_ack)) else $error("ack in standby");
  a_disp_once: assert property (display_req |=> !display_req) else $error("long pulse");
  a_disp_at_ack: assert property (display_req |-> $rose(host_ack)) else $error("display late");
  a_panel_at_ack: assert property (init_panel_white |-> $rose(host_ack)) else $error("init late");
  a_refresh_cause: assert property (refresh_req |-> $past(init_done)) else $error("refresh without init");
  a_sleep_quiet: assert property (!fast_clk_run |-> !display_req && !restore_req) else $error("acted in sleep");
endmodule
bind epdhcd_top epdhcd_sva i_epdhcd_sva (.ref_clk, .srst, .host_data_strobe_n, .host_rw, .host_ack, .host_data_oe_n,
  .init_done, .refresh_req, .restore_req, .display_req, .init_panel_white, .soft_reset_pulse, .depth_2bit,
  .orientation, .gradation_neg, .fast_clk_run, .standby_halt);

// File: verif/tb_top.sv
/*
  self-checking bench of the host command decoder with a host model.
  assumes the design files compiled with logic/ on the include path.
*/
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] VER = 8'h5A; // arbitrary value
  logic ref_clk, srst, wake_req, auto_refresh_on, init_done, pix_ready;
  logic [7:0] exp_b;
  logic [7:0] pix_q [$];
  int failures = 0, checks = 0, n_disp = 0, n_rest = 0, n_mem = 0, n_pan = 0, n_ref = 0, n_srst = 0;
  wire strobe_n, rw, cd, host_ack, host_data_oe_n, pix_valid, partial_busy, init_mem_white, init_panel_white;
  wire refresh_req, restore_req, display_req, soft_reset_pulse, depth_2bit, gradation_neg, fast_clk_run, standby_halt;
  wire [7:0] din, host_data_out, pix_data;
  wire [15:0] area_x1, area_y1, area_x2, area_y2;
  wire [1:0] orientation;
  epdhcd_host_model host (.ref_clk, .host_ack, .rdata(host_data_out), .strobe_n, .rw, .cd, .wdata(din));
  epdhcd_top #(.VERSION_CODE(VER)) i_epdhcd_top (.ref_clk, .srst, .host_data_strobe_n(strobe_n), .host_rw(rw),
    .host_cd(cd), .host_data_in(din), .host_data_out, .host_data_oe_n, .host_ack, .wake_req, .auto_refresh_on,
    .init_done, .pix_data, .pix_valid, .pix_ready, .area_x1, .area_y1, .area_x2, .area_y2, .partial_busy,
    .init_mem_white, .init_panel_white, .refresh_req, .restore_req, .display_req, .soft_reset_pulse, .depth_2bit,
    .orientation, .gradation_neg, .fast_clk_run, .standby_halt);
  // ==========================================
  // clock, pulse counters and pixel sink
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    n_disp += display_req === 1'b1;
    n_rest += restore_req === 1'b1;
    n_mem += init_mem_white === 1'b1;
    n_pan += init_panel_white === 1'b1;
    n_ref += refresh_req === 1'b1;
    n_srst += soft_reset_pulse === 1'b1;
    if (pix_valid === 1'b1 && pix_ready === 1'b1)
    begin
      exp_b = (pix_q.size() > 0) ? pix_q.pop_front() : 8'hxx;
      `CHK("pixel", exp_b, pix_data)
    end
  end
  // ==========================================
  // bus helpers
  task automatic w(input logic c, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(1'b0, c, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] e);
    logic [7:0] q;
    host.xfer(1'b1, 1'b0, 8'h00, q);
    `CHK(nm, e, q)
  endtask
  task automatic coords(input logic [7:0] x2, input logic [7:0] y2);
    logic [7:0] c [8];
    // corners on the four-pixel grid, top-left first
    c = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, x2, 8'h00, y2};
    w(1'b1, 8'hB0);
    foreach (c[i]) w(1'b0, c[i]);
  endtask
  // ==========================================
  // scenarios
  task automatic t_query();
    `CHK("orient rst", 2'h1, orientation)
    `CHK("neg rst", 1'b0, gradation_neg)
    w(1'b1, 8'hE2);
    rd_chk("size", 8'h22);
    w(1'b1, 8'hE0);
    rd_chk("version", VER);
    w(1'b1, 8'hAA);
    rd_chk("status", 8'h08);
  endtask
  task automatic t_settings();
    w(1'b1, 8'hF3);
    w(1'b0, 8'h02);
    `CHK("depth2", 1'b1, depth_2bit)
    w(1'b1, 8'hF3);
    w(1'b0, 8'h05);
    `CHK("depth rsv", 1'b1, depth_2bit)
    w(1'b1, 8'hAA);
    rd_chk("status depth", 8'h18);
    w(1'b1, 8'hF3);
    w(1'b0, 8'h00);
    `CHK("depth1", 1'b0, depth_2bit)
    for (int i = 0; i < 4; i++)
    begin
      w(1'b1, 8'hF5);
      w(1'b0, 8'(i));
      `CHK("orient", 2'(i), orientation)
    end
    w(1'b1, 8'hF8);
    `CHK("neg set", 1'b1, gradation_neg)
    w(1'b1, 8'hF7);
    `CHK("neg", 1'b0, gradation_neg)
  endtask
  task automatic t_init_disp();
    w(1'b1, 8'hA4);
    w(1'b0, 8'h01);
    `CHK("panel white", 1, n_pan)
    w(1'b1, 8'hA4);
    w(1'b0, 8'h00);
    `CHK("mem white", 1, n_mem)
    `CHK("early refresh", 0, n_ref)
    init_done <= 1'b1;
    @(posedge ref_clk);
    init_done <= 1'b0;
    repeat (4) @(posedge ref_clk);
    `CHK("refresh", 1, n_ref)
    w(1'b1, 8'hA2);
    `CHK("display", 1, n_disp)
    w(1'b1, 8'hB1);
    `CHK("display part", 2, n_disp)
    w(1'b1, 8'hA5);
    `CHK("restore", 1, n_rest)
    w(1'b1, 8'hAA);
    rd_chk("status shown", 8'h0C);
  endtask
  task automatic t_partial();
    pix_ready <= 1'b0;
    coords(8'h07, 8'h1F);
    `CHK("x2", 16'h0007, area_x2)
    `CHK("y2", 16'h001F, area_y2)
    `CHK("x1y1", 0, {area_x1, area_y1})
    for (int i = 0; i < 32; i++)
    begin
      pix_q.push_back(8'(i));
      if (i != 16)
        w(1'b0, 8'(i));
      else
        fork
          w(1'b0, 8'(i));
          begin
            repeat (20) @(posedge ref_clk);
            `CHK("full stall", 1'b0, host_ack)
            pix_ready <= 1'b1;
          end
        join
    end
    repeat (40) @(posedge ref_clk);
    `CHK("part done", 1'b0, partial_busy)
    `CHK("pix left", 0, pix_q.size())
    w(1'b1, 8'hAA);
    rd_chk("status loaded", 8'h0A);
    w(1'b1, 8'hB1);
    coords(8'h03, 8'h03);
    w(1'b1, 8'hA1);
    `CHK("stopped", 1'b0, partial_busy)
    w(1'b1, 8'hAA);
    rd_chk("status abort", 8'h0E);
  endtask
  task automatic t_power();
    int lost0;
    w(1'b1, 8'hF1);
    `CHK("sleep", 1'b0, fast_clk_run)
    auto_refresh_on <= 1'b0;
    w(1'b1, 8'hAA);
    rd_chk("status sleep", 8'h07);
    w(1'b1, 8'hA2);
    `CHK("sleep disp", 3, n_disp)
    w(1'b1, 8'hF0);
    `CHK("normal", 1'b1, fast_clk_run)
    w(1'b1, 8'hF5);
    w(1'b0, 8'h03);
    w(1'b1, 8'hEE);
    repeat (3) @(posedge ref_clk);
    `CHK("soft rst", 1, n_srst)
    `CHK("soft orient", 2'h1, orientation)
    repeat (2000) @(posedge ref_clk);
    w(1'b1, 8'hF2);
    `CHK("standby", 1'b1, standby_halt)
    lost0 = host.lost;
    w(1'b1, 8'hAA);
    `CHK("no ack", lost0 + 1, host.lost)
    repeat (60000) @(posedge ref_clk);
    wake_req <= 1'b1;
    repeat (2) @(posedge ref_clk);
    wake_req <= 1'b0;
    repeat (4) @(posedge ref_clk);
    `CHK("woken", 1'b0, standby_halt)
  endtask
  // ==========================================
  // run control
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #800000;
    failures++;
    print_verdict();
  end
  initial
  begin
    srst = 1'b1;
    wake_req = 1'b0;
    auto_refresh_on = 1'b1;
    init_done = 1'b0;
    pix_ready = 1'b1;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    t_query();
    t_settings();
    t_init_disp();
    t_partial();
    t_power();
    print_verdict();
  end
endmodule
